// ===== profile_word.sv
// one 32-bit configuration word with reserved-bit masking and nv load
`timescale 1ns/100ps
`default_nettype none
module profile_word
   import speed_profile_pkg::*;
#(
   parameter logic [31:0] word_mask = 32'hffff_ffff
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // software write
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   // nonvolatile image load
   input  wire logic        nv_en,
   input  wire logic [31:0] nv_data,
   // stored word
   output logic      [31:0] word
);
   typedef struct packed {
      logic [31:0] word_r;
   } word_state_t;

   word_state_t st_r;
   word_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      // nv image wins: it is applied even when a software write arrives in the same cycle
      if (nv_en) begin
         st_nxt.word_r = nv_data & word_mask;
      end else if (wr_en) begin
         st_nxt.word_r = wr_data & word_mask;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_r.word_r <= word_reset;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign word = st_r.word_r;
endmodule : profile_word
`default_nettype wire

// ===== speed_profile_config_regs.sv
// speed-profile configuration registers: duty clamp, speeds, breakpoints
`timescale 1ns/100ps
`default_nettype none
module speed_profile_config_regs
   import speed_profile_pkg::*;
(
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               resetn,
   // register port from the serial interface engine
   input  wire logic [7:0]         reg_addr,
   input  wire logic               reg_wr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_rd,
   output logic      [31:0]        reg_rdata,
   output logic                    reg_rvalid,
   // nonvolatile image, applied on a one-cycle pulse
   input  wire logic               nv_load,
   input  wire logic [31:0]        nv_duty_word,
   input  wire logic [31:0]        nv_prof_four,
   input  wire logic [31:0]        nv_prof_five,
   output logic                    nv_loaded,
   // decoded settings for the control loop
   output logic [speed_w-1:0]      clamp_point_duty,
   output logic [hyst_w-1:0]       reference_duty_hysteresis,
   output logic [speed_w-1:0]      turn_off_speed,
   output logic [speed_w-1:0]      clamp_speed,
   output logic [speed_w-1:0]      speed_point_a,
   output logic [speed_w-1:0]      speed_point_b,
   output logic [speed_w-1:0]      speed_point_c,
   output logic [speed_w-1:0]      speed_point_d,
   output logic [speed_w-1:0]      speed_point_e
);
   typedef struct packed {
      logic [31:0] rdata_r;
      logic        rvalid_r;
      logic        loaded_r;
   } port_state_t;

   localparam logic [31:0] masks [reg_count] =
      '{duty_word_mask, prof_four_mask, prof_five_mask};
   localparam logic [7:0]  offs  [reg_count] =
      '{duty_word_off, prof_four_off, prof_five_off};

   port_state_t        st_r;
   port_state_t        st_nxt;
   logic [31:0]        words   [reg_count];
   logic [31:0]        nv_img  [reg_count];
   logic [reg_count-1:0] wr_sel;

   assign nv_img[duty_idx] = nv_duty_word;
   assign nv_img[four_idx] = nv_prof_four;
   assign nv_img[five_idx] = nv_prof_five;

   generate
      for (genvar i = 0; i < reg_count; i++) begin : g_word
         assign wr_sel[i] = reg_wr && (reg_addr == offs[i]);
         profile_word #(
            .word_mask (masks[i])
         ) u_word (
            .ref_clk   (ref_clk),
            .resetn    (resetn),
            .wr_en     (wr_sel[i]),
            .wr_data   (reg_wdata),
            .nv_en     (nv_load),
            .nv_data   (nv_img[i]),
            .word      (words[i])
         );
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid_r = reg_rd;
      if (nv_load) begin
         st_nxt.loaded_r = 1'b1;
      end
      if (reg_rd) begin
         // unmapped offsets read as zero
         if (reg_addr == duty_word_off) begin
            st_nxt.rdata_r = words[duty_idx];
         end else if (reg_addr == prof_four_off) begin
            st_nxt.rdata_r = words[four_idx];
         end else if (reg_addr == prof_five_off) begin
            st_nxt.rdata_r = words[five_idx];
         end else begin
            st_nxt.rdata_r = read_zero;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_r.rdata_r  <= read_zero;
         st_r.rvalid_r <= 1'b0;
         st_r.loaded_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata  = st_r.rdata_r;
   assign reg_rvalid = st_r.rvalid_r;
   assign nv_loaded  = st_r.loaded_r;

   assign clamp_point_duty =
      words[duty_idx][duty_clamp_lsb +: speed_w];
   // hysteresis code; code 3h is passed through unchanged
   assign reference_duty_hysteresis = words[duty_idx][hyst_lsb +: hyst_w];
   assign turn_off_speed = words[four_idx][off_speed_lsb +: speed_w];
   assign clamp_speed    = words[four_idx][clamp_speed_lsb +: speed_w];
   assign speed_point_a  = words[four_idx][bp_a_lsb +: speed_w];
   // second breakpoint split across two words
   assign speed_point_b  = {words[four_idx][bp_b_hi_lsb +: bp_b_hi_w],
                            words[five_idx][bp_b_lo_bit]};
   assign speed_point_c  = words[five_idx][bp_c_lsb +: speed_w];
   assign speed_point_d  = words[five_idx][bp_d_lsb +: speed_w];
   assign speed_point_e  = words[five_idx][bp_e_lsb +: speed_w];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence wr_to(logic [7:0] off);
      reg_wr && !nv_load && reg_addr == off;
   endsequence

   duty_clamp_wr_a: assert property (
      wr_to(duty_word_off) |=> clamp_point_duty == $past(reg_wdata[10:3]))
      else $error("duty clamp did not take written value");
   hyst_code_wr_a: assert property (
      wr_to(duty_word_off) |=>
         reference_duty_hysteresis == $past(reg_wdata[2:1]))
      else $error("hysteresis code did not take written value");
   off_speed_wr_a: assert property (
      wr_to(prof_four_off) |=> turn_off_speed == $past(reg_wdata[30:23]))
      else $error("turn-off speed wrong after write");
   clamp_speed_wr_a: assert property (
      wr_to(prof_four_off) |=> clamp_speed == $past(reg_wdata[22:15]))
      else $error("clamp speed wrong after write");
   point_a_wr_a: assert property (
      wr_to(prof_four_off) |=> speed_point_a == $past(reg_wdata[14:7]))
      else $error("first breakpoint wrong after write");
   point_b_hi_a: assert property (
      wr_to(prof_four_off) |=>
         speed_point_b == {$past(reg_wdata[6:0]), $past(speed_point_b[0])})
      else $error("second breakpoint upper bits wrong");
   point_b_lo_a: assert property (
      wr_to(prof_five_off) |=>
         speed_point_b == {$past(speed_point_b[7:1]), $past(reg_wdata[30])})
      else $error("second breakpoint low bit wrong");
   points_cde_a: assert property (
      wr_to(prof_five_off) |=>
         speed_point_c == $past(reg_wdata[29:22]) &&
         speed_point_d == $past(reg_wdata[21:14]) &&
         speed_point_e == $past(reg_wdata[13:6]))
      else $error("breakpoints c, d or e wrong after write");
   reserved_read_a: assert property (
      reg_rd && !reg_wr && !nv_load && reg_addr == prof_five_off |=>
         reg_rvalid && (reg_rdata & ~prof_five_mask) == read_zero)
      else $error("reserved bits of word five read nonzero");
   nv_load_img_a: assert property (
      nv_load |=> nv_loaded && turn_off_speed == $past(nv_prof_four[30:23])
         ##1 nv_loaded)
      else $error("nv image not applied");

   // read path: answer one cycle on, fields read back in place
   sequence rd_at(logic [7:0] off);
      reg_rd && reg_addr == off;
   endsequence

   sequence rd_unmapped;
      reg_rd && reg_addr != duty_word_off && reg_addr != prof_four_off &&
         reg_addr != prof_five_off;
   endsequence

   sequence wr_unmapped;
      reg_wr && !nv_load && reg_addr != duty_word_off &&
         reg_addr != prof_four_off && reg_addr != prof_five_off;
   endsequence

   rvalid_rise_a: assert property (
      reg_rd |=> reg_rvalid)
      else $error("read answer missing one cycle after strobe");
   rvalid_pulse_a: assert property (
      !reg_rd |=> !reg_rvalid)
      else $error("read answer without a read strobe");
   duty_read_a: assert property (
      rd_at(duty_word_off) |=>
         reg_rdata == {21'h0, $past(clamp_point_duty),
                       $past(reference_duty_hysteresis), 1'b0})
      else $error("duty word read back wrong");
   four_read_a: assert property (
      rd_at(prof_four_off) |=>
         reg_rdata == {1'b0, $past(turn_off_speed), $past(clamp_speed),
                       $past(speed_point_a), $past(speed_point_b[7:1])})
      else $error("word four read back wrong");
   five_read_a: assert property (
      rd_at(prof_five_off) |=>
         reg_rdata == {1'b0, $past(speed_point_b[0]), $past(speed_point_c),
                       $past(speed_point_d), $past(speed_point_e), 6'h0})
      else $error("word five read back wrong");
   unmapped_read_a: assert property (
      rd_unmapped |=> reg_rvalid && reg_rdata == read_zero)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   unmapped_wr_a: assert property (
      wr_unmapped |=> $stable(clamp_point_duty) && $stable(turn_off_speed) &&
         $stable(speed_point_b) && $stable(speed_point_e))
      else $error("unmapped write changed a field");
   nv_wins_a: assert property (
      nv_load && reg_wr && reg_addr == prof_four_off |=>
         clamp_speed == $past(nv_prof_four[22:15]))
      else $error("software write beat the nv image");
   loaded_sticky_a: assert property (
      nv_loaded |=> nv_loaded)
      else $error("nv loaded flag dropped without reset");
endmodule : speed_profile_config_regs
`default_nettype wire

// ===== speed_profile_config_regs_tb.sv
// self-checking bench for the speed-profile configuration registers
`timescale 1ns/100ps
`default_nettype none
module speed_profile_config_regs_tb
   import speed_profile_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic        reg_wr = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        reg_rvalid;
   logic        nv_load = 1'b0;
   logic [31:0] nv_duty_word = 32'h0;
   logic [31:0] nv_prof_four = 32'h0;
   logic [31:0] nv_prof_five = 32'h0;
   logic        nv_loaded;
   logic [7:0]  cpd, tos, cls, spa, spb, spc, spd, spe;
   logic [1:0]  rdh;
   logic [31:0] m_duty, m_four, m_five, seed;
   logic [31:0] exp_q[$];
   int          n_fail = 0;
   int          total_checks = 0;
   int          cycles = 0;
   always #5 ref_clk = ~ref_clk;
   speed_profile_config_regs dut_u (.ref_clk(ref_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .nv_load(nv_load), .nv_duty_word(nv_duty_word),
      .nv_prof_four(nv_prof_four), .nv_prof_five(nv_prof_five),
      .nv_loaded(nv_loaded), .clamp_point_duty(cpd),
      .reference_duty_hysteresis(rdh), .turn_off_speed(tos),
      .clamp_speed(cls), .speed_point_a(spa), .speed_point_b(spb),
      .speed_point_c(spc), .speed_point_d(spd), .speed_point_e(spe));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_word
   task automatic cmp_field(input logic [7:0] got, input logic [7:0] exp);
      cmp_word({24'h0, got}, {24'h0, exp});
   endtask : cmp_field
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      exp_q.push_back(exp);
      @(negedge ref_clk);
      reg_rd = 1'b0;
   endtask : rd
   task automatic check_all();
      cmp_field(cpd, m_duty[10:3]);
      cmp_field({6'h0, rdh}, {6'h0, m_duty[2:1]});
      cmp_field(tos, m_four[30:23]);
      cmp_field(cls, m_four[22:15]);
      cmp_field(spa, m_four[14:7]);
      cmp_field(spb, {m_four[6:0], m_five[30]});
      cmp_field(spc, m_five[29:22]);
      cmp_field(spd, m_five[21:14]);
      cmp_field(spe, m_five[13:6]);
      rd(8'h98, m_duty);
      rd(8'h9a, m_four);
      rd(8'h9c, m_five);
   endtask : check_all
   // every read answer is taken against the oldest note
   always @(negedge ref_clk) begin
      if (reg_rvalid === 1'b1) begin
         // an answer with no note is a stray valid
         if (exp_q.size() == 0) cmp_word({31'h0, reg_rvalid}, 32'h0);
         else cmp_word(reg_rdata, exp_q.pop_front());
      end
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      seed = 32'hfa27;
      {m_duty, m_four, m_five} = '0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      resetn = 1'b1;
      check_all();
      cmp_field({7'h0, nv_loaded}, 8'h00);
      $display("test reset done");
      // nv image wins over a write in the same cycle
      @(negedge ref_clk);
      nv_duty_word = rnd();
      nv_prof_four = rnd();
      nv_prof_five = rnd();
      nv_load = 1'b1;
      reg_addr = 8'h9a;
      reg_wdata = rnd();
      reg_wr = 1'b1;
      @(negedge ref_clk);
      nv_load = 1'b0;
      reg_wr = 1'b0;
      m_duty = nv_duty_word & duty_word_mask;
      m_four = nv_prof_four & prof_four_mask;
      m_five = nv_prof_five & prof_five_mask;
      cmp_field({7'h0, nv_loaded}, 8'h01);
      check_all();
      $display("test nv load done");
      for (int i = 0; i < 8; i++) begin
         wr(8'h98, {rnd() | 32'hffff_f801});
         m_duty = reg_wdata & duty_word_mask;
         wr(8'h9a, rnd() | (i[0] ? 32'h8000_0000 : 32'h0));
         m_four = reg_wdata & prof_four_mask;
         wr(8'h9c, rnd() | 32'h8000_003f);
         m_five = reg_wdata & prof_five_mask;
         check_all();
      end
      $display("test writes done");
      for (int h = 0; h < 4; h++) begin
         wr(8'h98, {21'h0, 8'hff, h[1:0], 1'b0});
         m_duty = reg_wdata;
         check_all();
      end
      $display("test hysteresis done");
      // unmapped place: write dropped, read gives zero
      wr(8'h9e, rnd());
      rd(8'h9e, 32'h0);
      rd(8'h96, 32'h0);
      check_all();
      $display("test unmapped done");
      @(negedge ref_clk);
      resetn = 1'b0;
      @(negedge ref_clk);
      resetn = 1'b1;
      {m_duty, m_four, m_five} = '0;
      cmp_field({7'h0, nv_loaded}, 8'h00);
      check_all();
      repeat (4) @(negedge ref_clk);
      cmp_word(exp_q.size(), 32'h0);
      $display("test second reset done");
      give_verdict();
   end
endmodule : speed_profile_config_regs_tb
`default_nettype wire

// ===== speed_profile_pkg.sv
// constants for the speed-profile configuration register bank
`default_nettype none
package speed_profile_pkg;
   // register offsets (byte addresses on the internal register port)
   localparam logic [7:0]  duty_word_off      = 8'h98;
   localparam logic [7:0]  prof_four_off      = 8'h9a;
   localparam logic [7:0]  prof_five_off      = 8'h9c;
   localparam int          reg_count          = 3;
   localparam int          duty_idx           = 0;
   localparam int          four_idx           = 1;
   localparam int          five_idx           = 2;
   // implemented bits of each word; the rest are reserved
   localparam logic [31:0] duty_word_mask     = 32'h0000_07fe;
   localparam logic [31:0] prof_four_mask     = 32'h7fff_ffff;
   localparam logic [31:0] prof_five_mask     = 32'h7fff_ffc0;
   localparam logic [31:0] word_reset         = 32'h0000_0000;
   // field layout
   localparam int          speed_w            = 8;
   localparam int          hyst_w             = 2;
   localparam int          duty_clamp_lsb     = 3;
   localparam int          hyst_lsb           = 1;
   localparam int          off_speed_lsb      = 23;
   localparam int          clamp_speed_lsb    = 15;
   localparam int          bp_a_lsb           = 7;
   localparam int          bp_b_hi_lsb        = 0;
   localparam int          bp_b_hi_w          = 7;
   localparam int          bp_b_lo_bit        = 30;
   localparam int          bp_c_lsb           = 22;
   localparam int          bp_d_lsb           = 14;
   localparam int          bp_e_lsb           = 6;
   // hysteresis codes
   localparam logic [1:0]  hyst_none          = 2'h0;
   localparam logic [1:0]  hyst_half_pct      = 2'h1;
   localparam logic [1:0]  hyst_one_pct       = 2'h2;
   localparam logic [31:0] read_zero          = 32'h0000_0000;
endpackage : speed_profile_pkg
`default_nettype wire
